/* include/capture_regs.svh */
// register offsets, field positions, reset values and widths of the capture channel
`ifndef CAPTURE_REGS_SVH
`define CAPTURE_REGS_SVH

// ==========================================================
// register byte offsets (one aligned word each)
`define OFS_MODE     8'h00
`define OFS_START    8'h04
`define OFS_STOP     8'h08
`define OFS_ENABLED  8'h0c
`define OFS_COUNTER  8'h10
`define OFS_CAPTURE  8'h14
`define OFS_STATUS   8'h18
`define OFS_MASK     8'h1c

// ==========================================================
// mode register fields
`define MODE_OPMODE_LSB   0
`define MODE_EDGE_LSB     2
`define MODE_TRIG_BIT     4
`define MODE_CLKSEL_LSB   8
`define MODE_RESET        32'h0000_0000

// status / mask bits
`define ST_CAPTURE_BIT    0
`define MASK_RESET        1'h0

// ==========================================================
// widths and the counter zero value
`define COUNTER_W         16
`define CLKSEL_W          4
`define COUNTER_ZERO      16'h0000

`endif

/* include/capture_pkg.sv */
// types shared by the capture channel files
package capture_pkg;

  typedef enum logic [1:0] {
    opmode_interval,
    opmode_capture,
    opmode_rsvd2,
    opmode_rsvd3
  } opmode_e;

  typedef enum logic [1:0] {
    edge_falling,
    edge_rising,
    edge_both,
    edge_rsvd
  } edge_e;

endpackage

/* src/edge_detect.sv */
// valid-edge detector for the capture input pin
module edge_detect
  import capture_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire edge_e edge_sel_i,
  output logic valid_edge_o
);

  logic prev_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= pin_i;
    end
  end

  // rising only counts rising transitions; both accepts either
  always_comb begin
    case (edge_sel_i)
      edge_falling: valid_edge_o = prev_ff & ~pin_i;
      edge_rising: valid_edge_o = ~prev_ff & pin_i; // R6
      edge_both: valid_edge_o = prev_ff ^ pin_i;
      default: valid_edge_o = 1'b0;
    endcase
  end

endmodule

/* src/capture_channel.sv */
// pulse interval capture channel with a classic wishbone register slave
// =====================================================================
// Overview of operation
// R1 - on each valid edge in capture mode, counter is copied into capture register
// R2 - counter restarts at zero in the same cycle as the capture
// R3 - every capture sets the capture-done interrupt request
// R4 - writing one to start bit enables counting from zero
// R5 - writing one to stop bit disables counting
// R6 - valid edge is selectable; rising setting accepts rising transitions only
// R7 - operation clock selectable; setting zero is the undivided peripheral clock
// R8 - trigger source selectable; pin valid edge triggers capture
// R9 - operating mode selects capture mode, where edges capture the counter
// R10 - software discards the first capture after start
// R11 - software clears the request flag so later captures are seen
// R12 - while enabled, counter advances by one per operation clock tick
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`include "capture_regs.svh"

module capture_channel
  import capture_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic capture_input_pin_i,
  output logic capture_done_irq_o
);

  // =====================================================================
  // register state
  opmode_e opmode_ff;
  edge_e edge_sel_ff;
  logic trig_pin_ff;
  logic [`CLKSEL_W-1:0] clksel_ff;
  logic enabled_ff;
  logic [`COUNTER_W-1:0] channel_counter_ff;
  logic [`COUNTER_W-1:0] channel_capture_reg_ff;
  logic status_ff;
  logic mask_ff;
  logic irq_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [14:0] presc_ff;

  logic bus_req;
  logic wr_req;
  logic rd_req;
  logic valid_edge;
  logic capture_evt;
  logic tick;
  logic start_wr;
  logic stop_wr;
  logic status_rd;
  logic [31:0] nxt_rdata;
  logic [14:0] presc_mask;

  // single-cycle answer: ack rises the cycle after the request, then drops
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_req = bus_req & wb_we_i;
  assign rd_req = bus_req & ~wb_we_i;
  assign start_wr = wr_req && wb_adr_i == `OFS_START && wb_sel_i[0] && wb_dat_i[0];
  assign stop_wr = wr_req && wb_adr_i == `OFS_STOP && wb_sel_i[0] && wb_dat_i[0];
  assign status_rd = rd_req && wb_adr_i == `OFS_STATUS;

  // =====================================================================
  // edge detection and capture trigger
  edge_detect u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(capture_input_pin_i),
    .edge_sel_i(edge_sel_ff),
    .valid_edge_o(valid_edge)
  );

  // capture only with pin trigger, capture mode, and counting enabled
  assign capture_evt = valid_edge & trig_pin_ff & enabled_ff & (opmode_ff == opmode_capture); // R8 R9

  // =====================================================================
  // operation clock prescaler: divides by 2**clksel, clksel 0 ticks every cycle
  // one mask bit per prescaler stage; stage i is used when clksel exceeds i
  for (genvar i = 0; i < 15; i++) begin : g_mask
    assign presc_mask[i] = clksel_ff > 4'(i);
  end

  assign tick = (presc_ff & presc_mask) == 15'h0000; // R7

  always_ff @(posedge clk_i) begin
    if (rst_i || start_wr || !enabled_ff) begin
      presc_ff <= 15'h0000;
    end else begin
      presc_ff <= presc_ff + 15'h0001;
    end
  end

  // =====================================================================
  // configuration register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opmode_ff <= opmode_interval;
      edge_sel_ff <= edge_falling;
      trig_pin_ff <= 1'b0;
      clksel_ff <= '0;
    end else if (wr_req && wb_adr_i == `OFS_MODE) begin
      if (wb_sel_i[0]) begin
        opmode_ff <= opmode_e'(wb_dat_i[`MODE_OPMODE_LSB +: 2]); // R9
        edge_sel_ff <= edge_e'(wb_dat_i[`MODE_EDGE_LSB +: 2]); // R6
        trig_pin_ff <= wb_dat_i[`MODE_TRIG_BIT]; // R8
      end
      if (wb_sel_i[1]) begin
        clksel_ff <= wb_dat_i[`MODE_CLKSEL_LSB +: `CLKSEL_W]; // R7
      end
    end
  end

  // =====================================================================
  // start / stop control; start wins when both land together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enabled_ff <= 1'b0;
    end else if (start_wr) begin
      enabled_ff <= 1'b1; // R4
    end else if (stop_wr) begin
      enabled_ff <= 1'b0; // R5
    end
  end

  // =====================================================================
  // counter: cleared on start and on capture, else counts per tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_counter_ff <= `COUNTER_ZERO;
    end else if (start_wr) begin
      channel_counter_ff <= `COUNTER_ZERO; // R4
    end else if (capture_evt) begin
      channel_counter_ff <= `COUNTER_ZERO; // R2
    end else if (enabled_ff && tick) begin
      channel_counter_ff <= channel_counter_ff + 16'h0001; // R12
    end
  end

  // the first value after start spans from the start command, not an edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_capture_reg_ff <= `COUNTER_ZERO;
    end else if (capture_evt) begin
      channel_capture_reg_ff <= channel_counter_ff; // R1
    end
  end

  // =====================================================================
  // interrupt: sticky status, cleared by reading it; a new capture wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_ff <= 1'b0;
    end else if (capture_evt) begin
      status_ff <= 1'b1; // R3
    end else if (status_rd) begin
      status_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= `MASK_RESET;
    end else if (wr_req && wb_adr_i == `OFS_MASK && wb_sel_i[0]) begin
      mask_ff <= wb_dat_i[`ST_CAPTURE_BIT];
    end
  end

  // one cycle behind the status bit so the output comes from a flip-flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= status_ff & mask_ff; // R3
    end
  end

  // =====================================================================
  // read mux; unmapped offsets read zero and are still acknowledged
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `OFS_MODE: begin
        nxt_rdata[`MODE_OPMODE_LSB +: 2] = opmode_ff;
        nxt_rdata[`MODE_EDGE_LSB +: 2] = edge_sel_ff;
        nxt_rdata[`MODE_TRIG_BIT] = trig_pin_ff;
        nxt_rdata[`MODE_CLKSEL_LSB +: `CLKSEL_W] = clksel_ff;
      end
      `OFS_ENABLED: nxt_rdata[0] = enabled_ff;
      `OFS_COUNTER: nxt_rdata[`COUNTER_W-1:0] = channel_counter_ff;
      `OFS_CAPTURE: nxt_rdata[`COUNTER_W-1:0] = channel_capture_reg_ff;
      `OFS_STATUS: nxt_rdata[`ST_CAPTURE_BIT] = status_ff;
      `OFS_MASK: nxt_rdata[`ST_CAPTURE_BIT] = mask_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req;
      if (rd_req) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign capture_done_irq_o = irq_ff;

endmodule

/* dv/pulse_source.sv */
// pulse source model driving the capture input pin
module pulse_source (
  input logic clk_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin_o = 1'b0;
  // ==========================================
  // pulse shapes
  // high for half the gap, so falling edges land well clear of rising ones
  task automatic rise(input int gap);
    pin_o <= 1'b1;
    repeat (gap / 2) @(posedge clk_i);
    pin_o <= 1'b0;
    repeat (gap - gap / 2) @(posedge clk_i);
  endtask
  task automatic train(input int g1, input int g2);
    rise(g1);
    rise(g2);
    rise(30);
  endtask
endmodule

/* dv/capture_channel_asserts.sv */
// port checker of the capture channel
`include "capture_regs.svh"
module capture_channel_asserts (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic capture_done_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rd_s;
    wb_ack_o && !wb_we_i;
  endsequence
  // ==========================================
  // bus and interrupt relations
  ack_next_a: assert property (req_s |=> wb_ack_o) else $error("ack late");
  ack_one_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack idle");
  // irq is one cycle behind status, so it falls the cycle after the clearing access is acked
  irq_fall_a: assert property ($fell(capture_done_irq_o) |-> $past(wb_ack_o)) else $error("irq drop");
  odd_adr_a: assert property (rd_s and wb_adr_i > 8'h1c |-> wb_dat_o == 0) else $error("odd");
  en_bits_a: assert property (rd_s and wb_adr_i == `OFS_ENABLED |-> wb_dat_o[31:1] == 0)
    else $error("enabled bits");
  cnt_bits_a: assert property (rd_s and wb_adr_i == `OFS_COUNTER |-> wb_dat_o[31:16] == 0)
    else $error("counter bits");
  cap_bits_a: assert property (rd_s and wb_adr_i == `OFS_CAPTURE |-> wb_dat_o[31:16] == 0)
    else $error("capture bits");
endmodule

/* dv/capture_channel_bench.sv */
// self-checking bench of the capture channel
`include "capture_regs.svh"
module capture_channel_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack;
  logic irq;
  logic pin;
  logic [15:0] cap [3];
  int err_total = 0;
  int samples_checked = 0;
  always #5 clk_i = ~clk_i;
  capture_channel capture_channel_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .capture_input_pin_i(pin), .capture_done_irq_o(irq));
  pulse_source pulse_source_i (.clk_i(clk_i), .pin_o(pin));
  // ==========================================
  // shared tasks
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    rdat = dat_o;
    cyc <= 1'b0;
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (irq !== 1'b1 && n < 200);
    if (irq !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    wb(0, `OFS_MODE, 0);
    chk("mode", `MODE_RESET, rdat);
    wb(0, `OFS_MASK, 0);
    chk("mask", 0, rdat);
    wb(0, 8'h40, 0);
    chk("unmapped", 0, rdat);
  endtask
  task automatic t_measure;
    logic [15:0] c1;
    wb(1, `OFS_MODE, 32'h15);
    wb(1, `OFS_MASK, 1);
    wb(1, `OFS_START, 1);
    wb(0, `OFS_ENABLED, 0);
    chk("enabled", 1, rdat);
    wb(0, `OFS_COUNTER, 0);
    c1 = rdat[15:0];
    wb(0, `OFS_COUNTER, 0);
    chk("count step", 3, rdat - c1);
    fork
      pulse_source_i.train(40, 53);
      for (int i = 0; i < 3; i++) begin
        wait_irq();
        wb(0, `OFS_CAPTURE, 0);
        cap[i] = rdat[15:0];
        wb(0, `OFS_STATUS, 0);
        chk("status", 1, rdat);
      end
    join
    // the first capture spans from start, so only the later two are compared
    chk("interval", 13, cap[2] - cap[1]);
    chk("first gap", 39, cap[1]);
    chk("irq low", 0, irq);
    wb(0, `OFS_STATUS, 0);
    chk("falling ignored", 0, rdat);
  endtask
  task automatic t_refuse;
    wb(1, `OFS_STOP, 1);
    wb(0, `OFS_ENABLED, 0);
    chk("stopped", 0, rdat);
    pulse_source_i.rise(10);
    wb(0, `OFS_STATUS, 0);
    chk("idle stopped", 0, rdat);
    wb(1, `OFS_MODE, 32'h14);
    wb(1, `OFS_START, 1);
    pulse_source_i.rise(10);
    wb(0, `OFS_STATUS, 0);
    chk("idle interval", 0, rdat);
    wb(1, `OFS_MODE, 32'h05);
    pulse_source_i.rise(10);
    wb(0, `OFS_STATUS, 0);
    chk("idle no trigger", 0, rdat);
    wb(1, `OFS_MODE, 32'h15);
    wb(1, `OFS_MASK, 0);
    pulse_source_i.rise(10);
    chk("masked irq", 0, irq);
    wb(0, `OFS_STATUS, 0);
    chk("masked status", 1, rdat);
    wb(1, `OFS_MODE, 32'h11);
    pulse_source_i.rise(10);
    wb(0, `OFS_STATUS, 0);
    chk("falling edge", 1, rdat);
    wb(1, `OFS_MODE, 32'h19);
    pulse_source_i.rise(10);
    wb(0, `OFS_STATUS, 0);
    chk("both edges", 1, rdat);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_measure();
    t_refuse();
    report_and_stop();
  end
endmodule
bind capture_channel capture_channel_asserts capture_channel_asserts_i (.*);
